// >>> design/atp_top.sv
// Trace port unit: pin assignment, registers, formatter, sync insertion
// Assumes one clock equal to the bus clock; sources synchronous to it
//
// Operation
// - Trace pin unassigned after power-on reset
// - Enable bit with mode 00 routes trace
// - Config cleared only by power-on reset
// - Disabled pin: released, or test data out
// - Protocol field selects port, Manchester, NRZ
// - Frames of sixteen bytes
// - Mixed byte bit zero flags data or ID
// - Auxiliary bits: data bit zero or ID timing
// - Full sync word between frames only
// - Half sync word when port idle
// - Half sync only in continuous mode; full sync in any mode
// - Full sync after trace reset release
// - Trigger sends full sync, optional instrumentation sync
// - No sync counter; triggers from outside only
// - No synchronous multi-pin output
// - Bit time follows the bus clock
// - Registers gated by global trace enable
// - Port width register holds any written four-bit value
// - Formatter control fixed bits, continuous bit
// - Formatter status reads constant eight
`timescale 1ns/1ps
`include "atp_map.svh"
module atp_top
    import atp_pkg::*;
(
    // Clock and resets
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        power_on_reset_n_in,
    // Debug configuration register
    input  wire logic        dbg_cfg_wr_in,
    input  wire logic [31:0] dbg_cfg_wdata_in,
    output logic [31:0]      dbg_cfg_rdata_out,
    // Register bus
    input  wire logic        global_trace_enable_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Trace source
    input  wire logic        src_valid_in,
    input  wire logic [7:0]  src_data_in,
    input  wire logic [6:0]  src_id_in,
    output logic             src_ready_out,
    input  wire logic        sync_trigger_in,
    input  wire logic        instr_sync_enable_in,
    // Shared pin
    input  wire logic        jtag_mode_in,
    input  wire logic        test_data_out_in,
    input  wire logic        test_data_out_oe_in,
    output logic             serial_trace_out_out,
    output logic             serial_trace_out_oe_out
);

localparam logic [31:0] FFCTRL_RST = `ATP_RST_FFCTRL;
localparam logic [31:0] WIDTH_RST = `ATP_RST_WIDTH;

////////////////////////////////////////////////////////////////////////////////
// Debug configuration register

logic       pin_en_r, pin_en_nxt;
logic [1:0] mode_r, mode_nxt;
logic       trace_on;
logic       trace_rst_n;

always_comb
begin
    pin_en_nxt = pin_en_r;
    mode_nxt = mode_r;
    if (dbg_cfg_wr_in)
    begin
        pin_en_nxt = dbg_cfg_wdata_in[`ATP_CFG_PINEN];
        mode_nxt = dbg_cfg_wdata_in[`ATP_CFG_MODE_HI:`ATP_CFG_MODE_LO];
    end
end

always_ff @(posedge clk_in)
begin
    if (!power_on_reset_n_in)
    begin
        pin_en_r <= 1'b0;
        mode_r <= 2'h0;
    end
    else
    begin
        pin_en_r <= pin_en_nxt;
        mode_r <= mode_nxt;
    end
end

assign trace_on = pin_en_r && (mode_r == `ATP_TRACE_ASYNC);
assign trace_rst_n = power_on_reset_n_in && trace_on;
assign dbg_cfg_rdata_out = {24'h00_0000, mode_r, pin_en_r, 5'h00};

////////////////////////////////////////////////////////////////////////////////
// Register port

logic [3:0]  width_r, width_nxt;
atp_proto_t  proto_r, proto_nxt;
logic        cont_r, cont_nxt;
logic        cont_eff;
logic [31:0] prdata_r, prdata_nxt;
logic        apb_wr;
logic        apb_rd;

assign apb_wr = psel_in && penable_in && pwrite_in && global_trace_enable_in;
assign apb_rd = psel_in && !penable_in && !pwrite_in;
assign cont_eff = cont_r || (proto_r == ATP_PROTO_PORT);
assign prdata_out = prdata_r;
assign pready_out = 1'b1;
assign pslverr_out = 1'b0;

always_comb
begin
    width_nxt = width_r;
    proto_nxt = proto_r;
    cont_nxt = cont_r;
    prdata_nxt = prdata_r;
    if (apb_wr)
    begin
        if (paddr_in == `ATP_ADDR_WIDTH)
            width_nxt = pwdata_in[3:0];
        else if (paddr_in == `ATP_ADDR_PROTO)
            proto_nxt = atp_proto_t'(pwdata_in[1:0]);
        else if (paddr_in == `ATP_ADDR_FFCTRL && proto_r != ATP_PROTO_PORT)
            cont_nxt = pwdata_in[`ATP_FFCTRL_CONT];
    end
    if (apb_rd)
    begin
        if (!global_trace_enable_in)
            prdata_nxt = 32'h0000_0000;
        else if (paddr_in == `ATP_ADDR_WIDTH)
            prdata_nxt = {28'h000_0000, width_r};
        else if (paddr_in == `ATP_ADDR_PROTO)
            prdata_nxt = {30'h0000_0000, proto_r};
        else if (paddr_in == `ATP_ADDR_FFSTAT)
            prdata_nxt = `ATP_VAL_FFSTAT;
        else if (paddr_in == `ATP_ADDR_FFCTRL)
            prdata_nxt = {FFCTRL_RST[31:2], cont_eff, FFCTRL_RST[0]};
        else
            prdata_nxt = 32'h0000_0000;
    end
end

always_ff @(posedge clk_in)
begin
    if (!reset_n_in)
    begin
        width_r <= WIDTH_RST[3:0];
        proto_r <= atp_proto_t'(`ATP_RST_PROTO);
        cont_r <= FFCTRL_RST[`ATP_FFCTRL_CONT];
        prdata_r <= 32'h0000_0000;
    end
    else
    begin
        width_r <= width_nxt;
        proto_r <= proto_nxt;
        cont_r <= cont_nxt;
        prdata_r <= prdata_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Formatter input

logic [7:0] ent_byte_r [15];
logic [7:0] ent_byte_nxt [15];
logic       ent_id_r [15];
logic       ent_id_nxt [15];
logic       ent_dly_r [15];
logic       ent_dly_nxt [15];
logic [3:0] pos_r, pos_nxt;
logic [6:0] cur_id_r, cur_id_nxt;
logic [2:0] isync_cnt_r, isync_cnt_nxt;
logic       fsync_pend_r, fsync_pend_nxt;
logic       isync_active;
logic       in_valid;
logic       in_bad;
logic [6:0] in_id;
logic [7:0] in_byte;
logic       frame_full;
logic       frame_done;
logic       fmt_take;
logic [3:0] pos_prev;

assign isync_active = (isync_cnt_r != 3'h0) && !(isync_cnt_r == `ATP_ISYNC_LEN && fsync_pend_r);
assign in_valid = isync_active || src_valid_in;
assign in_id = isync_active ? `ATP_ISYNC_ID : src_id_in;
assign in_byte = !isync_active ? src_data_in :
                 (isync_cnt_r == `ATP_ISYNC_LEN) ? `ATP_ISYNC_HEAD : 8'h00;
assign in_bad = !isync_active && (src_id_in == `ATP_BAD_ID);
assign frame_full = (pos_r == `ATP_FRAME_LAST);
assign pos_prev = pos_r - 4'h1;
assign src_ready_out = !isync_active && (in_bad || fmt_take);

always_comb
begin
    ent_byte_nxt = ent_byte_r;
    ent_id_nxt = ent_id_r;
    ent_dly_nxt = ent_dly_r;
    pos_nxt = pos_r;
    cur_id_nxt = cur_id_r;
    fmt_take = 1'b0;
    if (frame_done)
        pos_nxt = 4'h0;
    else if (in_valid && !frame_full && !in_bad)
    begin
        if (in_id != cur_id_r)
        begin
            cur_id_nxt = in_id;
            if (pos_r[0] && ent_id_r[pos_prev])
                ent_byte_nxt[pos_prev] = {1'b0, in_id};
            else if (pos_r[0])
            begin
                ent_byte_nxt[pos_prev] = {1'b0, in_id};
                ent_id_nxt[pos_prev] = 1'b1;
                ent_dly_nxt[pos_prev] = 1'b1;
                ent_byte_nxt[pos_r] = ent_byte_r[pos_prev];
                ent_id_nxt[pos_r] = 1'b0;
                pos_nxt = pos_r + 4'h1;
            end
            else
            begin
                ent_byte_nxt[pos_r] = {1'b0, in_id};
                ent_id_nxt[pos_r] = 1'b1;
                ent_dly_nxt[pos_r] = 1'b0;
                pos_nxt = pos_r + 4'h1;
            end
        end
        else
        begin
            ent_byte_nxt[pos_r] = in_byte;
            ent_id_nxt[pos_r] = 1'b0;
            ent_dly_nxt[pos_r] = 1'b0;
            pos_nxt = pos_r + 4'h1;
            fmt_take = 1'b1;
        end
    end
end

always_ff @(posedge clk_in)
begin
    if (!trace_rst_n)
    begin
        ent_byte_r <= '{default: 8'h00};
        ent_id_r <= '{default: 1'b0};
        ent_dly_r <= '{default: 1'b0};
        pos_r <= 4'h0;
        cur_id_r <= 7'h00;
    end
    else
    begin
        ent_byte_r <= ent_byte_nxt;
        ent_id_r <= ent_id_nxt;
        ent_dly_r <= ent_dly_nxt;
        pos_r <= pos_nxt;
        cur_id_r <= cur_id_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Frame assembly

logic [7:0] fbyte [16];
logic [7:0] aux_byte;

genvar gi;
generate
    for (gi = 0; gi < 8; gi++)
    begin : g_slot
        assign fbyte[2*gi] = ent_id_r[2*gi] ? {ent_byte_r[2*gi][6:0], 1'b1} :
                                              {ent_byte_r[2*gi][7:1], 1'b0};
        assign aux_byte[gi] = ent_id_r[2*gi] ? ent_dly_r[2*gi] : ent_byte_r[2*gi][0];
        if (gi < 7)
        begin : g_data
            assign fbyte[2*gi+1] = ent_byte_r[2*gi+1];
        end
    end
endgenerate
assign fbyte[15] = aux_byte;

////////////////////////////////////////////////////////////////////////////////
// Output scheduler

atp_out_state_t out_state_r, out_state_nxt;
logic [3:0]     oidx_r, oidx_nxt;
logic [7:0]     obyte;
logic           ovalid;
logic           oready;
logic           olast;

assign ovalid = (out_state_r != OUT_IDLE);

always_comb
begin
    out_state_nxt = out_state_r;
    oidx_nxt = oidx_r;
    fsync_pend_nxt = fsync_pend_r;
    isync_cnt_nxt = isync_cnt_r;
    frame_done = 1'b0;
    case (out_state_r)
        OUT_FULL:
        begin
            obyte = (oidx_r == `ATP_FULL_LAST) ? `ATP_SYNC_LAST : `ATP_SYNC_BYTE;
            olast = (oidx_r == `ATP_FULL_LAST);
        end
        OUT_HALF:
        begin
            obyte = (oidx_r == `ATP_HALF_LAST) ? `ATP_SYNC_LAST : `ATP_SYNC_BYTE;
            olast = (oidx_r == `ATP_HALF_LAST);
        end
        OUT_FRAME:
        begin
            obyte = fbyte[oidx_r];
            olast = (oidx_r == `ATP_FRAME_LAST);
        end
        default:
        begin
            obyte = `ATP_SYNC_BYTE;
            olast = 1'b0;
        end
    endcase
    case (out_state_r)
        OUT_IDLE:
        begin
            if (fsync_pend_r)
            begin
                out_state_nxt = OUT_FULL;
                fsync_pend_nxt = 1'b0;
            end
            else if (frame_full)
                out_state_nxt = OUT_FRAME;
            else if (cont_eff && !in_valid)
                out_state_nxt = OUT_HALF;
        end
        default:
        begin
            if (oready)
            begin
                if (olast)
                begin
                    out_state_nxt = OUT_IDLE;
                    oidx_nxt = 4'h0;
                    frame_done = (out_state_r == OUT_FRAME);
                end
                else
                    oidx_nxt = oidx_r + 4'h1;
            end
        end
    endcase
    if (isync_active && fmt_take)
        isync_cnt_nxt = isync_cnt_r - 3'h1;
    if (sync_trigger_in)
    begin
        fsync_pend_nxt = 1'b1;
        if (instr_sync_enable_in && isync_cnt_r == 3'h0)
            isync_cnt_nxt = `ATP_ISYNC_LEN;
    end
end

always_ff @(posedge clk_in)
begin
    if (!trace_rst_n)
    begin
        out_state_r <= OUT_IDLE;
        oidx_r <= 4'h0;
        fsync_pend_r <= 1'b1;
        isync_cnt_r <= 3'h0;
    end
    else
    begin
        out_state_r <= out_state_nxt;
        oidx_r <= oidx_nxt;
        fsync_pend_r <= fsync_pend_nxt;
        isync_cnt_r <= isync_cnt_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Line encoder and pin assignment

logic ser_line;

atp_serializer u_ser (
    .clk_in         (clk_in),
    .rst_n_in       (trace_rst_n),
    .proto_in       (proto_r),
    .byte_valid_in  (ovalid),
    .byte_in        (obyte),
    .byte_ready_out (oready),
    .line_out       (ser_line)
);

always_comb
begin
    if (trace_on)
    begin
        serial_trace_out_out = ser_line;
        serial_trace_out_oe_out = 1'b1;
    end
    else if (jtag_mode_in)
    begin
        serial_trace_out_out = test_data_out_in;
        serial_trace_out_oe_out = test_data_out_oe_in;
    end
    else
    begin
        serial_trace_out_out = 1'b0;
        serial_trace_out_oe_out = 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Checks

a_pin_unassigned:
    assert property (@(posedge clk_in) disable iff (!power_on_reset_n_in)
        !$past(power_on_reset_n_in) |-> !trace_on && (jtag_mode_in || !serial_trace_out_oe_out))
    else $error("Trace pin assigned after power-on reset");
a_swd_released:
    assert property (@(posedge clk_in) disable iff (!power_on_reset_n_in)
        (!trace_on && !jtag_mode_in) |-> !serial_trace_out_oe_out)
    else $error("Pin not released with trace off");
a_trace_route:
    assert property (@(posedge clk_in) disable iff (!power_on_reset_n_in)
        trace_on |-> serial_trace_out_oe_out && (serial_trace_out_out == ser_line))
    else $error("Trace not routed to pin");
a_cfg_in_reset:
    assert property (@(posedge clk_in) disable iff (!power_on_reset_n_in)
        (!reset_n_in && dbg_cfg_wr_in) |=> pin_en_r == $past(dbg_cfg_wdata_in[5]))
    else $error("Config write lost under system reset");
a_read_gated:
    assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (apb_rd && !global_trace_enable_in) |=> prdata_out == 32'h0000_0000)
    else $error("Read not zero with trace disabled");
a_ffctrl_port:
    assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (apb_rd && global_trace_enable_in && paddr_in == 32'hE004_0304 && proto_r == ATP_PROTO_PORT)
        |=> prdata_out == 32'h0000_0102)
    else $error("Formatter control read wrong");
a_ffstat_const:
    assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (apb_rd && global_trace_enable_in && paddr_in == 32'hE004_0300) |=> prdata_out == 32'h0000_0008)
    else $error("Formatter status read wrong");
a_first_sync:
    assert property (@(posedge clk_in) disable iff (!power_on_reset_n_in)
        $rose(trace_on) |=> out_state_r == OUT_FULL && isync_cnt_r == 3'h0)
    else $error("No full sync after trace reset release");
a_mixed_flag:
    assert property (@(posedge clk_in) disable iff (!trace_rst_n)
        (out_state_r == OUT_FRAME && !oidx_r[0] && oidx_r != 4'hF) |-> obyte[0] == ent_id_r[oidx_r])
    else $error("Mixed byte flag wrong");

endmodule

// >>> design/atp_map.svh
// Trace port unit address map, field positions, reset values and timing
// Definitions only; included by the design modules
`ifndef ATP_MAP_SVH
`define ATP_MAP_SVH
`define ATP_ADDR_WIDTH  32'hE004_0004
`define ATP_ADDR_PROTO  32'hE004_00F0
`define ATP_ADDR_FFSTAT 32'hE004_0300
`define ATP_ADDR_FFCTRL 32'hE004_0304
`define ATP_RST_WIDTH   32'h0000_0001
`define ATP_RST_PROTO   2'h1
`define ATP_VAL_FFSTAT  32'h0000_0008
`define ATP_RST_FFCTRL  32'h0000_0102
`define ATP_FFCTRL_CONT 1
`define ATP_CFG_PINEN   5
`define ATP_CFG_MODE_LO 6
`define ATP_CFG_MODE_HI 7
`define ATP_TRACE_ASYNC 2'h0
`define ATP_SYNC_BYTE   8'hFF
`define ATP_SYNC_LAST   8'h7F
`define ATP_BAD_ID      7'h7F
`define ATP_ISYNC_HEAD  8'h80
`define ATP_ISYNC_LEN   3'h6
`define ATP_ISYNC_ID    7'h01
`define ATP_FULL_LAST   4'h3
`define ATP_HALF_LAST   4'h1
`define ATP_FRAME_LAST  4'hF
`define ATP_NRZ_BITS    4'hA
`define ATP_MAN_BITS    4'h9
`define ATP_CLK_NS      100
`define ATP_BIT_NS      800
`define ATP_HALF_CYCLES (`ATP_BIT_NS / 2 / `ATP_CLK_NS)
`endif

// >>> design/atp_pkg.sv
// Types shared by the trace port unit modules
// No dependencies
package atp_pkg;
    typedef enum logic [1:0] {ATP_PROTO_PORT, ATP_PROTO_MANCH, ATP_PROTO_NRZ, ATP_PROTO_RSVD} atp_proto_t;
    typedef enum logic [1:0] {OUT_IDLE, OUT_FULL, OUT_FRAME, OUT_HALF} atp_out_state_t;
endpackage

// >>> design/atp_serializer.sv
// Serial line encoder for the trace pin, Manchester or NRZ
// Assumes byte source holds data stable while valid
`timescale 1ns/1ps
`include "atp_map.svh"
module atp_serializer
    import atp_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Line format
    input  wire atp_proto_t proto_in,
    // Byte stream
    input  wire logic       byte_valid_in,
    input  wire logic [7:0] byte_in,
    output logic            byte_ready_out,
    // Serial line
    output logic            line_out
);

localparam logic [7:0] HALF_LAST = 8'(`ATP_HALF_CYCLES - 1);

logic [9:0] shift_r, shift_nxt;
logic [3:0] bits_r, bits_nxt;
logic [7:0] tick_r, tick_nxt;
logic       half_r, half_nxt;
logic       line_r, line_nxt;
logic       nrz;
logic       run;

assign nrz = (proto_in == ATP_PROTO_NRZ);
assign run = nrz || (proto_in == ATP_PROTO_MANCH);
assign byte_ready_out = run && (bits_r == 4'h0);
assign line_out = line_r;

always_comb
begin
    shift_nxt = shift_r;
    bits_nxt = bits_r;
    tick_nxt = tick_r;
    half_nxt = half_r;
    line_nxt = nrz;
    if (byte_ready_out && byte_valid_in)
    begin
        shift_nxt = nrz ? {1'b1, byte_in, 1'b0} : {1'b0, byte_in, 1'b1};
        bits_nxt = nrz ? `ATP_NRZ_BITS : `ATP_MAN_BITS;
        tick_nxt = 8'h00;
        half_nxt = 1'b0;
    end
    else if (bits_r != 4'h0)
    begin
        line_nxt = nrz ? shift_r[0] : (shift_r[0] ^ half_r);
        if (tick_r == HALF_LAST)
        begin
            tick_nxt = 8'h00;
            half_nxt = !half_r;
            if (half_r)
            begin
                shift_nxt = {1'b0, shift_r[9:1]};
                bits_nxt = bits_r - 4'h1;
            end
        end
        else
            tick_nxt = tick_r + 8'h01;
    end
end

always_ff @(posedge clk_in)
begin
    if (!rst_n_in)
    begin
        shift_r <= 10'h000;
        bits_r <= 4'h0;
        tick_r <= 8'h00;
        half_r <= 1'b0;
        line_r <= nrz;
    end
    else
    begin
        shift_r <= shift_nxt;
        bits_r <= bits_nxt;
        tick_r <= tick_nxt;
        half_r <= half_nxt;
        line_r <= line_nxt;
    end
end

a_nrz_start:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (byte_valid_in && byte_ready_out && nrz) |-> ##2 (!line_out) [*8])
    else $error("NRZ start bit missing");
a_man_start:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (byte_valid_in && byte_ready_out && proto_in == ATP_PROTO_MANCH)
        |-> ##2 line_out [*4] ##1 (!line_out) [*4])
    else $error("Manchester start bit wrong");

endmodule

// >>> tb/atp_trace_analyzer.sv
// Trace port analyzer model: decodes NRZ bytes from the serial trace pin
// Assumes the line changes on the rising clock edge and idles high between bytes
`timescale 1ns/1ps
module atp_trace_analyzer
#(
    parameter int BIT_CYCLES = 8
)
(
    // Clock
    input  wire logic  clk_in,
    // Serial pin
    input  wire logic  line_in,
    input  wire logic  oe_in,
    // Decoded bytes
    output logic [7:0] byte_out,
    output logic       byte_valid_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] shift = 8'h00;
    logic       prev  = 1'b0;
    initial byte_out = 8'h00;
    initial byte_valid_out = 1'b0;
    always
    begin
        @(posedge clk_in);
        byte_valid_out <= 1'b0;
        if (oe_in === 1'b1 && prev === 1'b1 && line_in === 1'b0)
        begin
            // Mid-bit sampling leaves margin for bit-rate drift
            repeat (BIT_CYCLES / 2 - 1) @(posedge clk_in);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYCLES) @(posedge clk_in);
                shift[i] = line_in;
            end
            repeat (BIT_CYCLES) @(posedge clk_in);
            if (line_in === 1'b1)
            begin
                byte_out <= shift;
                byte_valid_out <= 1'b1;
            end
        end
        prev = oe_in & line_in;
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the trace port unit
// Assumes the design package and address map header are compiled first
`timescale 1ns/1ps
`include "atp_map.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    ////////////////////////////////////////////////////////////////////////
    logic        clk_in = 1'b0, reset_n_in = 1'b0, power_on_reset_n_in = 1'b0;
    logic        dbg_cfg_wr_in = 1'b0, global_trace_enable_in = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic        src_valid_in = 1'b0, sync_trigger_in = 1'b0, instr_sync_enable_in = 1'b0;
    logic        jtag_mode_in = 1'b0, test_data_out_in = 1'b0, test_data_out_oe_in = 1'b0;
    logic [31:0] dbg_cfg_wdata_in = 32'h0000_0000, paddr_in = 32'h0000_0000, pwdata_in = 32'h0000_0000;
    logic [31:0] dbg_cfg_rdata_out, prdata_out;
    logic [7:0]  src_data_in = 8'h00, rx_byte, aux;
    logic [6:0]  src_id_in = 7'h00;
    logic        pready_out, pslverr_out, src_ready_out, serial_trace_out_out, serial_trace_out_oe_out, rx_valid;
    logic [7:0]  rxq[$];
    int          fail_count = 0;
    int          compares   = 0;

    always #50 clk_in = ~clk_in;

    atp_top atp_top_i (.clk_in, .reset_n_in, .power_on_reset_n_in, .dbg_cfg_wr_in, .dbg_cfg_wdata_in,
        .dbg_cfg_rdata_out, .global_trace_enable_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .src_valid_in, .src_data_in, .src_id_in,
        .src_ready_out, .sync_trigger_in, .instr_sync_enable_in, .jtag_mode_in, .test_data_out_in,
        .test_data_out_oe_in, .serial_trace_out_out, .serial_trace_out_oe_out);

    atp_trace_analyzer #(.BIT_CYCLES(2 * `ATP_HALF_CYCLES)) atp_trace_analyzer_i (.clk_in,
        .line_in(serial_trace_out_out), .oe_in(serial_trace_out_oe_out), .byte_out(rx_byte),
        .byte_valid_out(rx_valid));

    always @(posedge clk_in)
        if (rx_valid === 1'b1)
            rxq.push_back(rx_byte);

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1; pwrite_in <= 1'b1; paddr_in <= a; pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        psel_in <= 1'b0; penable_in <= 1'b0;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk_in);
        psel_in <= 1'b1; pwrite_in <= 1'b0; paddr_in <= a;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        psel_in <= 1'b0; penable_in <= 1'b0;
        `CHK(prdata_out, e)
    endtask

    task automatic cfg(input logic [31:0] d);
        @(posedge clk_in);
        dbg_cfg_wr_in <= 1'b1; dbg_cfg_wdata_in <= d;
        @(posedge clk_in);
        dbg_cfg_wr_in <= 1'b0;
        #1;
    endtask

    task automatic send(input logic [6:0] id, input logic [7:0] d);
        int n = 0;
        @(posedge clk_in);
        src_valid_in <= 1'b1; src_id_in <= id; src_data_in <= d;
        do begin @(posedge clk_in); n++; end while (src_ready_out !== 1'b1 && n < 500);
        src_valid_in <= 1'b0;
        if (src_ready_out !== 1'b1)
            fail_count++;
    endtask

    task automatic exp(input logic [7:0] e, input logic [7:0] m);
        int n = 0;
        logic [7:0] b;
        while (rxq.size() == 0 && n < 2000)
        begin
            @(posedge clk_in);
            n++;
        end
        b = (rxq.size() > 0) ? rxq.pop_front() : 8'hxx;
        `CHK(b & m, e & m)
    endtask

    task automatic sync_word(input int n);
        for (int i = 1; i < n; i++)
            exp(`ATP_SYNC_BYTE, 8'hFF);
        exp(`ATP_SYNC_LAST, 8'hFF);
    endtask

    function automatic logic [7:0] dat(input int i);
        return 8'((i * 37) >> 1);
    endfunction

    task automatic print_verdict;
        $display("Mismatches %0d, compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        print_verdict();
    end

    initial
    begin
        repeat (20) @(posedge clk_in);
        power_on_reset_n_in <= 1'b1;
        @(posedge clk_in);
        #1 `CHK(serial_trace_out_oe_out, 1'b0)
        cfg(32'h0000_0040);
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1 `CHK(dbg_cfg_rdata_out, 32'h0000_0040)
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1 `CHK(dbg_cfg_rdata_out, 32'h0000_0040)
        @(posedge clk_in);
        power_on_reset_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        power_on_reset_n_in <= 1'b1;
        #1 `CHK(dbg_cfg_rdata_out, 32'h0000_0000)
        // Shared pin while trace is off
        @(posedge clk_in);
        jtag_mode_in <= 1'b1; test_data_out_oe_in <= 1'b1; test_data_out_in <= 1'b1;
        @(posedge clk_in);
        #1 `CHK({serial_trace_out_out, serial_trace_out_oe_out}, 2'b11)
        @(posedge clk_in);
        test_data_out_in <= 1'b0;
        @(posedge clk_in);
        #1 `CHK(serial_trace_out_out, 1'b0)
        @(posedge clk_in);
        jtag_mode_in <= 1'b0;
        @(posedge clk_in);
        #1 `CHK(serial_trace_out_oe_out, 1'b0)
        // Register port
        rchk(`ATP_ADDR_WIDTH, 32'h0000_0000);
        wr(`ATP_ADDR_WIDTH, 32'h0000_0008);
        @(posedge clk_in);
        global_trace_enable_in <= 1'b1;
        rchk(`ATP_ADDR_WIDTH, `ATP_RST_WIDTH);
        rchk(`ATP_ADDR_FFSTAT, `ATP_VAL_FFSTAT);
        rchk(`ATP_ADDR_PROTO, 32'h0000_0001);
        rchk(`ATP_ADDR_FFCTRL, `ATP_RST_FFCTRL);
        rchk(32'hE004_0008, 32'h0000_0000);
        wr(`ATP_ADDR_WIDTH, 32'h0000_0008);
        rchk(`ATP_ADDR_WIDTH, 32'h0000_0008);
        wr(`ATP_ADDR_FFCTRL, 32'h0000_0000);
        for (int p = 0; p < 4; p++)
        begin
            wr(`ATP_ADDR_PROTO, 32'(p));
            rchk(`ATP_ADDR_PROTO, 32'(p));
            rchk(`ATP_ADDR_FFCTRL, (p == 0) ? 32'h0000_0102 : 32'h0000_0100);
            if (p == 0)
                wr(`ATP_ADDR_FFCTRL, 32'h0000_0002);
        end
        wr(`ATP_ADDR_PROTO, 32'h0000_0002);
        // Pin assignment and initial sync
        cfg(32'h0000_0060);
        `CHK(serial_trace_out_oe_out, 1'b0)
        cfg(32'h0000_0020);
        `CHK(serial_trace_out_oe_out, 1'b1)
        sync_word(4);
        repeat (300) @(posedge clk_in);
        `CHK(rxq.size(), 0)
        @(posedge clk_in);
        sync_trigger_in <= 1'b1;
        @(posedge clk_in);
        sync_trigger_in <= 1'b0;
        sync_word(4);
        // One full frame from source 5
        for (int i = 0; i < 14; i++)
            send(7'h05, dat(i));
        exp(8'h0B, 8'hFF);
        aux = 8'h00;
        for (int i = 0; i < 14; i++)
        begin
            exp((i % 2 == 0) ? dat(i) : (dat(i) & 8'hFE), 8'hFF);
            if (i % 2 == 1)
                aux[(i + 1) / 2] = 1'(dat(i));
        end
        exp(aux, 8'hFF);
        wr(`ATP_ADDR_FFCTRL, 32'h0000_0002);
        sync_word(2);
        print_verdict();
    end
endmodule
